// ===== sim/pssr_cmd_top_properties.sv
module pssr_cmd_props
    import pssr_pkg::*;
(
    input wire logic                  clk_in,
    input wire logic                  sys_rst_in,
    input wire logic [7:0]            rx_byte_in,
    input wire logic                  rx_valid_in,
    input wire logic                  from_program_in,
    input wire logic                  ready_out,
    input wire logic                  reply_valid_out,
    input wire pssr_pkg::pssr_reply_t reply_out,
    input wire logic [31:0]           accumulator_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Counts edges from reset release until the restore walk ends.
    logic [8:0] init_cnt;
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            init_cnt <= 9'h000;
        end else if (!ready_out) begin
            init_cnt <= init_cnt + 9'h001;
        end
    end

    // A good reply, named once for the checks below.
    wire logic ok_rep = reply_valid_out && (reply_out.status == STAT_OK);

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_pulse;
        reply_valid_out ##1 !reply_valid_out;
    endsequence

    chk_reply_timing: assert property (reply_valid_out |-> $past(rx_valid_in, 2))
        else $error("reply not two edges after a byte");
    chk_reply_pulse: assert property ($rose(reply_valid_out) |-> s_pulse)
        else $error("reply strobe longer than one cycle");
    chk_ready_hold: assert property (ready_out |=> ready_out)
        else $error("ready dropped without reset");
    chk_ready_delay: assert property ($rose(ready_out) |-> init_cnt == 9'h100)
        else $error("restore walk length wrong");
    chk_no_early_reply: assert property (!ready_out |-> !reply_valid_out)
        else $error("reply before restore finished");
    chk_store_zero: assert property (ok_rep && reply_out.instr inside {8'h05, 8'h07, 8'h08, 8'h09, 8'h0B, 8'h0C}
        |-> reply_out.value == VALUE_ZERO)
        else $error("store or restore reply value not zero");
    chk_host_acc: assert property (reply_valid_out && !$past(from_program_in) |-> $stable(accumulator_out))
        else $error("host read changed accumulator");
    chk_prog_acc: assert property (ok_rep && reply_out.instr == INSTR_READ_GLOBAL && $past(from_program_in)
        |-> accumulator_out == reply_out.value)
        else $error("program read did not load accumulator");
endmodule : pssr_cmd_props

bind pssr_cmd_top pssr_cmd_props i_props (.clk_in, .sys_rst_in, .rx_byte_in, .rx_valid_in, .from_program_in,
    .ready_out, .reply_valid_out, .reply_out, .accumulator_out);

// ===== sim/pssr_cmd_top_tb.sv
module pssr_cmd_top_tb;
    import pssr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [7:0]  instr;
        logic [7:0]  ptype;
        logic [7:0]  bank;
        logic [31:0] value;
        logic        prog;
        logic [7:0]  status;
        logic [31:0] rval;
    } pssr_row_t;

    logic        clk_in, sys_rst_in, rx_valid_in, from_program, ready_out, reply_valid_out;
    logic [7:0]  rx_byte_in;
    logic [31:0] accumulator_out, exp_acc;
    pssr_reply_t reply_out;
    int          errors, checks;

    pssr_row_t rows [17] = '{
        '{8'h05, 8'h06, 8'h00, 32'h1234_5678, 1'b0, 8'h64, 32'h0},
        '{8'h07, 8'h06, 8'h00, 32'hDEAD_BEEF, 1'b0, 8'h64, 32'h0},
        '{8'h05, 8'h06, 8'h00, 32'h0000_0011, 1'b0, 8'h64, 32'h0},
        '{8'h06, 8'h06, 8'h00, 32'h0, 1'b0, 8'h64, 32'h0000_0011},
        '{8'h08, 8'h06, 8'h00, 32'hFFFF_FFFF, 1'b0, 8'h64, 32'h0},
        '{8'h06, 8'h06, 8'h00, 32'h0, 1'b0, 8'h64, 32'h1234_5678},
        '{8'h09, 8'h42, 8'h00, 32'h0000_0003, 1'b0, 8'h64, 32'h0},
        '{8'h0A, 8'h42, 8'h00, 32'h0, 1'b1, 8'h64, 32'h0000_0003},
        '{8'h09, 8'h2A, 8'h02, 32'hA5A5_0001, 1'b0, 8'h64, 32'h0},
        '{8'h0B, 8'h2A, 8'h02, 32'h0, 1'b0, 8'h64, 32'h0},
        '{8'h09, 8'h2A, 8'h02, 32'h0000_0BAD, 1'b0, 8'h64, 32'h0},
        '{8'h0C, 8'h2A, 8'h02, 32'h0, 1'b0, 8'h64, 32'h0},
        '{8'h0A, 8'h2A, 8'h02, 32'h0, 1'b0, 8'h64, 32'hA5A5_0001},
        '{8'h09, 8'h01, 8'h03, 32'h0000_0077, 1'b0, 8'h64, 32'h0},
        '{8'h0A, 8'h01, 8'h03, 32'h0, 1'b1, 8'h64, 32'h0000_0077},
        '{8'h0B, 8'h2A, 8'h00, 32'h0, 1'b0, 8'h04, 32'h0},
        '{8'h2F, 8'h00, 8'h00, 32'h0, 1'b0, 8'h02, 32'h0}
    };

    pssr_cmd_top i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .rx_byte_in(rx_byte_in),
        .rx_valid_in(rx_valid_in), .from_program_in(from_program), .ready_out(ready_out),
        .reply_valid_out(reply_valid_out), .reply_out(reply_out), .accumulator_out(accumulator_out));
    pssr_host_model i_host (.clk_in(clk_in), .rx_byte_out(rx_byte_in), .rx_valid_out(rx_valid_in));

    // Free-running 100 MHz clock.
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic finish_test();
        $display("Summary: %0d checks, %0d errors", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Pulses reset, then waits a bounded time for the restore walk.
    task automatic reset_dut();
        int n;
        n = 0;
        @(negedge clk_in);
        sys_rst_in = 1'b1;
        repeat (5) @(negedge clk_in);
        sys_rst_in = 1'b0;
        while (n < 300 && ready_out !== 1'b1) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        check({47'h0, ready_out}, 48'h1);
        if (ready_out !== 1'b1) finish_test();
    endtask : reset_dut

    // Sends a frame and compares the reply; a zero status means no reply is allowed.
    task automatic do_cmd(input logic [7:0] ad, ins, pt, bk, input logic [31:0] val, input logic prog,
                          input logic [7:0] err, input int read_axis_setting_cmd, input logic [47:0] exp);
        int n;
        n = 0;
        @(negedge clk_in);
        from_program = prog;
        i_host.send_frame(pssr_frame_t'{ad, ins, pt, bk, val}, err, read_axis_setting_cmd);
        while (n < 30 && reply_valid_out !== 1'b1) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        if (exp[47:40] === 8'h00) begin
            check({16'h0, 32'(n)}, 48'h1E);
        end else begin
            check(reply_out, exp);
            if (n == 30) begin
                errors++;
                finish_test();
            end
        end
    endtask : do_cmd

    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        errors = 0;
        checks = 0;
        exp_acc = 32'h0;
        from_program = 1'b0;
        sys_rst_in = 1'b1;
        reset_dut();
        foreach (rows[i]) begin
            do_cmd(MODULE_ADDR, rows[i].instr, rows[i].ptype, rows[i].bank, rows[i].value, rows[i].prog,
                   8'h00, 0, {rows[i].status, rows[i].instr, rows[i].rval});
            if (rows[i].prog && rows[i].instr == INSTR_READ_GLOBAL) exp_acc = rows[i].rval;
            check({16'h0, accumulator_out}, {16'h0, exp_acc});
        end
        do_cmd(MODULE_ADDR, 8'h09, 8'h42, 8'h00, 32'h9, 1'b0, 8'h01, 3, {8'h01, 8'h09, 32'h0});
        do_cmd(MODULE_ADDR, 8'h0A, 8'h42, 8'h00, 32'h0, 1'b0, 8'h00, 0, {8'h64, 8'h0A, 32'h3});
        do_cmd(8'h02, 8'h09, 8'h42, 8'h00, 32'h5, 1'b0, 8'h00, 0, 48'h0);
        do_cmd(MODULE_ADDR, 8'h0A, 8'h42, 8'h00, 32'h0, 1'b0, 8'h00, 0, {8'h64, 8'h0A, 32'h3});
        do_cmd(MODULE_ADDR, 8'h05, 8'h06, 8'h00, 32'h55, 1'b0, 8'h00, 0, {8'h64, 8'h05, 32'h0});
        reset_dut();
        do_cmd(MODULE_ADDR, 8'h06, 8'h06, 8'h00, 32'h0, 1'b0, 8'h00, 1, {8'h64, 8'h06, 32'h1234_5678});
        do_cmd(MODULE_ADDR, 8'h0A, 8'h42, 8'h00, 32'h0, 1'b0, 8'h00, 0, {8'h64, 8'h0A, 32'h3});
        do_cmd(MODULE_ADDR, 8'h0A, 8'h2A, 8'h02, 32'h0, 1'b0, 8'h00, 0, {8'h64, 8'h0A, 32'hA5A5_0001});
        check({16'h0, accumulator_out}, 48'h0);
        finish_test();
    end
endmodule : pssr_cmd_top_tb

// ===== sim/pssr_host_model.sv
module pssr_host_model
    import pssr_pkg::*;
(
    input  wire logic       clk_in,
    output logic [7:0]      rx_byte_out,
    output logic            rx_valid_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle link shows a changing byte so stale data never looks valid.
    initial begin
        rx_byte_out  = 8'hA5;
        rx_valid_out = 1'b0;
    end

    // Sends one frame, value MSB first, with read_axis_setting_cmd idle cycles between bytes.
    task automatic send_frame(input pssr_pkg::pssr_frame_t f, input logic [7:0] err, input int read_axis_setting_cmd);
        logic [71:0] fr;
        logic [7:0]  sum;
        sum = 8'h00;
        for (int i = 0; i < 8; i++) begin
            sum = sum + f[63 - 8 * i -: 8];
        end
        fr = {f, sum ^ err};
        for (int i = 0; i < 9; i++) begin
            @(negedge clk_in);
            rx_byte_out  <= fr[71 - 8 * i -: 8];
            rx_valid_out <= 1'b1;
            if (i < 8) begin
                repeat (read_axis_setting_cmd) begin
                    @(negedge clk_in);
                    rx_valid_out <= 1'b0;
                    rx_byte_out  <= ~rx_byte_out;
                end
            end
        end
        @(negedge clk_in);
        rx_valid_out <= 1'b0;
        rx_byte_out  <= ~rx_byte_out;
    endtask : send_frame
endmodule : pssr_host_model

// ===== verilog/pssr_cmd_top.sv
// Summary of operation
// - Code 7 saves axis setting to nonvolatile.
// - Code 8 reloads axis setting from nonvolatile.
// - Power-up loads all axis settings first.
// - Code 9 writes value into bank 0/2/3.
// - Bank 0 module, 2 user, 3 interrupt.
// - Bank 0 writes also save to nonvolatile.
// - Code 10 reads global into reply, and into accumulator for program reads.
// - Code 11 bank 2 saves user variable.
// - Code 12 bank 2 reloads user variable.
// - Power-up loads all user variables.
// - Store/restore replies status 100, value zero.
// - Axis writes stay volatile until saved.
// - Host-link reads leave accumulator unchanged.
module pssr_cmd_top
    import pssr_pkg::*;
(
    input  wire logic                 clk_in,
    input  wire logic                 sys_rst_in,
    input  wire logic [7:0]           rx_byte_in,
    input  wire logic                 rx_valid_in,
    input  wire logic                 from_program_in,
    output logic                      ready_out,
    output logic                      reply_valid_out,
    output pssr_pkg::pssr_reply_t     reply_out,
    output logic [31:0]               accumulator_out
);

    // ------------------------------------------------------------
    // Frame reception
    // ------------------------------------------------------------
    // The receiver raises frame_ok or frame_bad for one cycle after the ninth byte.
    // The fields then stand in frame until the next frame completes.
    pssr_frame_t frame;
    logic        frame_ok;
    logic        frame_bad;

    pssr_frame_rx u_rx (
        .clk_in        (clk_in),
        .sys_rst_in    (sys_rst_in),
        .rx_byte_in    (rx_byte_in),
        .rx_valid_in   (rx_valid_in),
        .frame_out     (frame),
        .frame_ok_out  (frame_ok),
        .frame_bad_out (frame_bad)
    );

    // ------------------------------------------------------------
    // Working and nonvolatile tables
    // ------------------------------------------------------------
    // Nonvolatile tables have no reset, so they keep their contents across sys_rst_in.
    // That is how a power cycle is modelled here; bank three has no stored copy.
    logic [31:0] axis_work   [PARAM_DEPTH];
    logic [31:0] axis_nv     [PARAM_DEPTH];
    logic [31:0] module_work [PARAM_DEPTH];
    logic [31:0] module_nv   [PARAM_DEPTH];
    logic [31:0] user_work   [PARAM_DEPTH];
    logic [31:0] user_nv     [PARAM_DEPTH];
    logic [31:0] irq_work    [PARAM_DEPTH];

    // Restore walk state and the table index that it visits.
    pssr_state_t state;
    logic [7:0]  init_idx;

    // Checks a bank code against the three banks that exist.
    // Global reads and writes accept exactly these banks and no other.
    function automatic logic bank_valid(input logic [7:0] bank);
        bank_valid = (bank == BANK_MODULE) || (bank == BANK_USER) || (bank == BANK_IRQ);
    endfunction : bank_valid

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    // Frames that complete while the restore walk runs are dropped without a reply.
    // Frames for another address are ignored whatever their checksum.
    wire        addressed  = (frame.addr == MODULE_ADDR);
    wire        idle       = (state == ST_IDLE);
    wire        take       = idle && frame_ok && addressed;
    wire        take_bad   = idle && frame_bad && addressed;
    wire [7:0]  ix         = frame.ptype;
    wire        bank_zero  = (frame.bank == BANK_MODULE);
    wire        bank_user  = (frame.bank == BANK_USER);
    wire        bank_any   = bank_valid(frame.bank);
    wire        bank_irq   = (frame.bank == BANK_IRQ);

    wire is_wr_axis   = (frame.instr == INSTR_WRITE_AXIS);
    wire is_rd_axis   = (frame.instr == INSTR_READ_AXIS);
    wire is_save_axis = (frame.instr == INSTR_SAVE_AXIS);
    wire is_rld_axis  = (frame.instr == INSTR_RELOAD_AXIS);
    wire is_wr_glob   = (frame.instr == INSTR_WRITE_GLOBAL);
    wire is_rd_glob   = (frame.instr == INSTR_READ_GLOBAL);
    wire is_save_user = (frame.instr == INSTR_SAVE_USER);
    wire is_rld_user  = (frame.instr == INSTR_RELOAD_USER);

    // Instruction groups, each with its own bank rule.
    wire axis_cmd  = is_wr_axis || is_rd_axis || is_save_axis || is_rld_axis;
    wire glob_cmd  = is_wr_glob || is_rd_glob;
    wire user_cmd  = is_save_user || is_rld_user;
    wire known_cmd = axis_cmd || glob_cmd || user_cmd;

    // Reads are the only commands that may touch the accumulator.
    wire is_read   = is_rd_axis || is_rd_glob;

    // Axis commands need bank zero, global commands a valid bank, user commands bank two.
    wire bank_fits = (axis_cmd && bank_zero) || (glob_cmd && bank_any) || (user_cmd && bank_user);
    wire exec      = take && known_cmd && bank_fits;

    // Read data for a global fetch, steered by bank.
    // Any other bank never reaches a reply value, since bank_fits refuses it.
    wire [31:0] glob_rd = bank_zero ? module_work[ix] :
                          bank_user ? user_work[ix] :
                                      irq_work[ix];

    // Reply value: reads return data, store and restore return zero.
    wire [31:0] rd_value = is_rd_axis ? axis_work[ix] :
                           is_rd_glob ? glob_rd :
                                        VALUE_ZERO;

    // Status priority is checksum, then instruction, then bank.
    wire [7:0]  next_status = take_bad   ? STAT_BAD_SUM :
                              !known_cmd ? STAT_BAD_CMD :
                              !bank_fits ? STAT_BAD_VALUE :
                                           STAT_OK;

    // Refused frames reply with a zero value.
    wire [31:0] next_value = exec ? rd_value : VALUE_ZERO;

    // The accumulator follows reads only when the program issued them.
    wire acc_load = exec && from_program_in && is_read;

    // ------------------------------------------------------------
    // Table updates
    // ------------------------------------------------------------
    // A save copies the working value that stood before this edge.
    // A read in the next frame already sees whatever this edge writes.
    // Rejected frames leave every table untouched.
    // Tables are memories without reset; power-up copies nonvolatile into working.
    always_ff @(posedge clk_in) begin
        if (state == ST_INIT) begin
            axis_work[init_idx]   <= axis_nv[init_idx];
            user_work[init_idx]   <= user_nv[init_idx];
            module_work[init_idx] <= module_nv[init_idx];
        end else if (exec) begin
            if (is_wr_axis) begin
                axis_work[ix] <= frame.value;
            end
            if (is_save_axis) begin
                axis_nv[ix] <= axis_work[ix];
            end
            if (is_rld_axis) begin
                axis_work[ix] <= axis_nv[ix];
            end
            if (is_wr_glob && bank_zero) begin
                module_work[ix] <= frame.value;
                module_nv[ix]   <= frame.value;
            end
            if (is_wr_glob && bank_user) begin
                user_work[ix] <= frame.value;
            end
            if (is_wr_glob && bank_irq) begin
                irq_work[ix] <= frame.value;
            end
            if (is_save_user) begin
                user_nv[ix] <= user_work[ix];
            end
            if (is_rld_user) begin
                user_work[ix] <= user_nv[ix];
            end
        end
    end

    // ------------------------------------------------------------
    // Control state and replies
    // ------------------------------------------------------------
    // Walks every table index once after reset, then accepts frames.
    // The walk takes one edge per index, so ready_out rises on the 256th edge
    // after reset is released.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state     <= ST_INIT;
            init_idx  <= INIT_FIRST;
            ready_out <= 1'b0;
        end else begin
            case (state)
                ST_INIT: begin
                    init_idx <= init_idx + 8'h01;
                    if (init_idx == INIT_LAST) begin
                        state     <= ST_IDLE;
                        ready_out <= 1'b1;
                    end
                end
                ST_IDLE: begin
                    ready_out <= 1'b1;
                end
                default: begin
                    state     <= ST_INIT;
                    ready_out <= 1'b0;
                end
            endcase
        end
    end

    // Issues one reply per addressed frame that completes in ST_IDLE and loads the accumulator on program reads.
    // Reply fields hold until the next reply; only the strobe is a one-cycle pulse.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reply_valid_out <= 1'b0;
            reply_out       <= REPLY_RST;
            accumulator_out <= VALUE_ZERO;
        end else begin
            reply_valid_out <= take || take_bad;
            if (take || take_bad) begin
                reply_out <= '{status: next_status, instr: frame.instr, value: next_value};
            end
            if (acc_load) begin
                accumulator_out <= rd_value;
            end
        end
    end

endmodule : pssr_cmd_top

// ===== verilog/pssr_frame_rx.sv
module pssr_frame_rx
    import pssr_pkg::*;
(
    input  wire logic                 clk_in,
    input  wire logic                 sys_rst_in,
    input  wire logic [7:0]           rx_byte_in,
    input  wire logic                 rx_valid_in,
    output pssr_pkg::pssr_frame_t     frame_out,
    output logic                      frame_ok_out,
    output logic                      frame_bad_out
);

    // ------------------------------------------------------------
    // Byte gathering and checksum
    // ------------------------------------------------------------
    logic [3:0]  cnt;
    logic [7:0]  sum;
    logic [63:0] shift;

    wire last_byte = rx_valid_in && (cnt == 4'(FRAME_LAST_IDX));
    wire sum_match = (sum == rx_byte_in);

    // Gathers eight bytes MSB first, then checks the ninth against their sum.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt           <= FRAME_CNT_RST;
            sum           <= SUM_RST;
            shift         <= '0;
            frame_out     <= FRAME_RST;
            frame_ok_out  <= 1'b0;
            frame_bad_out <= 1'b0;
        end else begin
            frame_ok_out  <= last_byte && sum_match;
            frame_bad_out <= last_byte && !sum_match;
            if (last_byte) begin
                cnt       <= FRAME_CNT_RST;
                sum       <= SUM_RST;
                frame_out <= pssr_frame_t'(shift);
            end else if (rx_valid_in) begin
                cnt   <= cnt + 4'h1;
                sum   <= sum + rx_byte_in;
                shift <= {shift[55:0], rx_byte_in};
            end
        end
    end

endmodule : pssr_frame_rx

// ===== verilog/pssr_pkg.sv
package pssr_pkg;

    // ------------------------------------------------------------
    // Frame layout and sizes
    // ------------------------------------------------------------
    localparam int unsigned FRAME_LAST_IDX = 8;           // Index of the checksum byte in a nine-byte frame.
    localparam logic [3:0]  FRAME_CNT_RST  = 4'h0;
    localparam logic [7:0]  SUM_RST        = 8'h00;
    localparam logic [7:0]  MODULE_ADDR    = 8'h01;       // Target address this module answers to.
    localparam int unsigned PARAM_DEPTH    = 256;         // Entries per parameter table, one per type code.
    localparam logic [7:0]  INIT_FIRST     = 8'h00;
    localparam logic [7:0]  INIT_LAST      = 8'hFF;

    // ------------------------------------------------------------
    // Instruction codes
    // ------------------------------------------------------------
    localparam logic [7:0] INSTR_WRITE_AXIS   = 8'h05;    // write_axis_setting_cmd
    localparam logic [7:0] INSTR_READ_AXIS    = 8'h06;    // read_axis_setting_cmd
    localparam logic [7:0] INSTR_SAVE_AXIS    = 8'h07;    // save_axis_setting_cmd
    localparam logic [7:0] INSTR_RELOAD_AXIS  = 8'h08;    // reload_axis_setting_cmd
    localparam logic [7:0] INSTR_WRITE_GLOBAL = 8'h09;    // write_global_setting_cmd
    localparam logic [7:0] INSTR_READ_GLOBAL  = 8'h0A;    // read_global_setting_cmd
    localparam logic [7:0] INSTR_SAVE_USER    = 8'h0B;    // save_user_variable_cmd
    localparam logic [7:0] INSTR_RELOAD_USER  = 8'h0C;    // reload_user_variable_cmd

    // ------------------------------------------------------------
    // Banks and reply status codes
    // ------------------------------------------------------------
    localparam logic [7:0] BANK_MODULE = 8'h00;
    localparam logic [7:0] BANK_USER   = 8'h02;
    localparam logic [7:0] BANK_IRQ    = 8'h03;

    localparam logic [7:0]  STAT_OK        = 8'h64;       // Decimal 100.
    localparam logic [7:0]  STAT_BAD_SUM   = 8'h01;
    localparam logic [7:0]  STAT_BAD_CMD   = 8'h02;
    localparam logic [7:0]  STAT_BAD_VALUE = 8'h04;
    localparam logic [31:0] VALUE_ZERO     = 32'h0000_0000;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  addr;
        logic [7:0]  instr;
        logic [7:0]  ptype;
        logic [7:0]  bank;
        logic [31:0] value;
    } pssr_frame_t;

    typedef struct packed {
        logic [7:0]  status;
        logic [7:0]  instr;
        logic [31:0] value;
    } pssr_reply_t;

    localparam pssr_frame_t FRAME_RST = '0;
    localparam pssr_reply_t REPLY_RST = '0;

    typedef enum logic [1:0] {
        ST_INIT = 2'b00,
        ST_IDLE = 2'b01
    } pssr_state_t;

endpackage : pssr_pkg
